//--- design/pin_port_pkg.sv
// ****************************************************************
// shared constants and types of the per-core pin input port
// ****************************************************************
package pin_port_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int unsigned PIN_COUNT  = 32;   // pins of the first port
   localparam int unsigned ADDR_W     = 8;    // apb byte address width
   localparam int unsigned DATA_W     = 32;   // apb data width
   localparam int unsigned PIN_IDX_W  = 5;    // bits of a pin number

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] OFF_PIN_INPUT_STATE_A = 8'h00;  // live pins, read only
   localparam logic [7:0] OFF_PIN_INPUT_STATE_B = 8'h04;  // reserved port, reads zero
   localparam logic [7:0] OFF_PIN_OUTPUT_A      = 8'h08;  // this core's output bits
   localparam logic [7:0] OFF_PIN_DIRECTION_A   = 8'h0C;  // this core's drive enables
   localparam logic [7:0] OFF_RANGE_SELECT      = 8'h10;  // pin field selection
   localparam logic [7:0] OFF_RANGE_RESULT      = 8'h14;  // extracted pin field

   // ****************************************************************
   // field positions of the range select register
   // ****************************************************************
   localparam int unsigned SEL_FIRST_LSB  = 0;   // first-named pin, 5 bits
   localparam int unsigned SEL_LAST_LSB   = 8;   // last-named pin, 5 bits
   localparam int unsigned SEL_SINGLE_BIT = 16;  // 1: single pin read of first

   // ****************************************************************
   // values after reset
   // ****************************************************************
   localparam logic [31:0] RST_PIN_OUTPUT  = 32'h0000_0000;
   localparam logic [31:0] RST_PIN_DIR     = 32'h0000_0000;
   localparam logic [31:0] RST_READ_DATA   = 32'h0000_0000;
   localparam logic [31:0] RST_SYNC        = 32'h0000_0000;

   // ****************************************************************
   // cycle counts
   // ****************************************************************
   localparam int unsigned SYNC_STAGES    = 2;  // flops in front of the read path
   localparam int unsigned APB_WAIT_STATES = 0; // access phase always one cycle

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed
   {
      logic                 single;  // single pin read
      logic [4:0]           last;    // last-named pin
      logic [4:0]           first;   // first-named pin
   } range_sel_t;

   localparam range_sel_t RST_RANGE_SEL = '{single: 1'b0, last: 5'h00, first: 5'h00};

endpackage : pin_port_pkg

//--- design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// two flop synchroniser, one lane per bit
// ****************************************************************
module pin_sync
#(
   parameter int unsigned WIDTH = 32
)
(
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] i_async,
   output var  logic [WIDTH-1:0] o_sync
);
   import pin_port_pkg::*;

   logic [WIDTH-1:0] meta_q;   // first stage, read only by the second

   // first stage: may go metastable, nothing else looks at it
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         meta_q <= WIDTH'(RST_SYNC);
      end
      else
      begin
         meta_q <= i_async;
      end
   end

   // second stage: the only consumer of the first
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         o_sync <= WIDTH'(RST_SYNC);
      end
      else
      begin
         o_sync <= meta_q;
      end
   end

endmodule : pin_sync
`default_nettype wire

//--- design/pin_field_extract.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// pin field extraction: single pin, forward or reversed range
// ****************************************************************
module pin_field_extract
(
   // pin word and selection
   input  wire logic [31:0]              i_value,
   input  wire pin_port_pkg::range_sel_t i_sel,
   // right-aligned field
   output var  logic [31:0]              o_field
);
   import pin_port_pkg::*;

   logic       reversed;   // first-named pin is the lower one
   logic [4:0] span;       // field width minus one

   // field width and direction from the two pin numbers
   always_comb
   begin
      reversed = (i_sel.first < i_sel.last);
      span     = reversed ? (i_sel.last - i_sel.first) : (i_sel.first - i_sel.last);
   end

   // each result bit up to span picks one pin, higher bits stay clear; the first-named pin always lands on top
   always_comb
   begin
      o_field = 32'h0000_0000;
      for (int j = 0; j < 32; j++)
      begin
         if (i_sel.single)
         begin
            // only bit 0 carries the pin, rest stay clear
            if (j == 0)
            begin
               o_field[0] = i_value[i_sel.first];
            end
         end
         else if (5'(j) <= span)
         begin
            // reversed walks down from last, forward walks up from last
            if (reversed)
            begin
               o_field[j] = i_value[i_sel.last - 5'(j)];
            end
            else
            begin
               o_field[j] = i_value[i_sel.last + 5'(j)];
            end
         end
      end
   end

endmodule : pin_field_extract
`default_nettype wire

//--- design/per_core_pin_input_port.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module per_core_pin_input_port
(
   // clock and reset
   input  wire logic                                I_CLK,
   input  wire logic                                I_RESET,
   // apb slave
   input  wire logic                                I_PSEL,
   input  wire logic                                I_PENABLE,
   input  wire logic                                I_PWRITE,
   input  wire logic [pin_port_pkg::ADDR_W-1:0]     I_PADDR,
   input  wire logic [pin_port_pkg::DATA_W-1:0]     I_PWDATA,
   input  wire logic [3:0]                          I_PSTRB,
   output var  logic [pin_port_pkg::DATA_W-1:0]     O_PRDATA,
   output var  logic                                O_PREADY,
   output var  logic                                O_PSLVERR,
   // pins and the other cores
   input  wire logic [pin_port_pkg::PIN_COUNT-1:0]  I_PIN_LEVEL,
   input  wire logic [pin_port_pkg::PIN_COUNT-1:0]  I_PEER_OUT,
   input  wire logic [pin_port_pkg::PIN_COUNT-1:0]  I_PEER_DIR,
   output var  logic [pin_port_pkg::PIN_COUNT-1:0]  O_PIN_OUT,
   output var  logic [pin_port_pkg::PIN_COUNT-1:0]  O_PIN_OE
);
   import pin_port_pkg::*;

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [31:0] pin_sync_w;     // synchronised pin levels
   logic [31:0] field_w;        // extracted pin field
   logic [31:0] own_out_q;      // this core's output bits
   logic [31:0] own_dir_q;      // this core's drive enables
   range_sel_t  sel_q;          // field selection
   logic [31:0] rd_mux;         // read data of the addressed register
   logic        setup;          // apb setup cycle
   logic        done;           // apb completion edge
   logic        mapped;         // address hits a register
   logic        ro_hit;         // address is the read-only pin word or the field result
   logic        bad;            // access answered with an error
   logic [31:0] strb_mask;      // byte lanes as a bit mask
   logic [4:0]  span_w;         // range width minus one, for checking

   // ****************************************************************
   // pin capture
   // ****************************************************************

   // external levels are asynchronous, so two flops before any reader
   pin_sync
   #(
      .WIDTH (PIN_COUNT)
   )
   u_pin_sync
   (
      .i_clk   (I_CLK),
      .i_reset (I_RESET),
      .i_async (I_PIN_LEVEL),
      .o_sync  (pin_sync_w)
   );

   // field extraction reads the same synchronised word as the full read
   pin_field_extract u_extract
   (
      .i_value (pin_sync_w),
      .i_sel   (sel_q),
      .o_field (field_w)
   );

   // ****************************************************************
   // apb decode
   // ****************************************************************

   // setup, completion, decode and byte lane mask
   always_comb
   begin
      setup     = I_PSEL & ~I_PENABLE;
      done      = I_PSEL & I_PENABLE & O_PREADY;
      mapped    = (I_PADDR == OFF_PIN_INPUT_STATE_A) | (I_PADDR == OFF_PIN_INPUT_STATE_B) |
                  (I_PADDR == OFF_PIN_OUTPUT_A) | (I_PADDR == OFF_PIN_DIRECTION_A) |
                  (I_PADDR == OFF_RANGE_SELECT) | (I_PADDR == OFF_RANGE_RESULT);
      // live pin word and the field result hold no storage, writes are refused; reserved port takes them without error
      ro_hit    = (I_PADDR == OFF_PIN_INPUT_STATE_A) | (I_PADDR == OFF_RANGE_RESULT);
      bad       = ~mapped | (I_PWRITE & ro_hit);
      strb_mask = {{8{I_PSTRB[3]}}, {8{I_PSTRB[2]}}, {8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};
   end

   // read multiplexer; pin word ignores direction entirely
   always_comb
   begin
      case (I_PADDR)
         OFF_PIN_INPUT_STATE_A : rd_mux = pin_sync_w;
         OFF_PIN_INPUT_STATE_B : rd_mux = 32'h0000_0000;
         OFF_PIN_OUTPUT_A      : rd_mux = own_out_q;
         OFF_PIN_DIRECTION_A   : rd_mux = own_dir_q;
         OFF_RANGE_SELECT      : rd_mux = {15'h0000, sel_q.single, 3'h0, sel_q.last,
                                           3'h0, sel_q.first};
         OFF_RANGE_RESULT      : rd_mux = field_w;
         default               : rd_mux = 32'h0000_0000;
      endcase
   end

   // ****************************************************************
   // apb answer
   // ****************************************************************

   // ready in the first access cycle: no wait states ever
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         O_PREADY <= 1'b0;
      end
      else
      begin
         O_PREADY <= setup;
      end
   end

   // pins are sampled at the setup edge, which is the moment of access
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         O_PRDATA <= RST_READ_DATA;
      end
      else if (setup & ~I_PWRITE)
      begin
         O_PRDATA <= mapped ? rd_mux : 32'h0000_0000;
      end
   end

   // error for unmapped offsets and for writes to the read-only words
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         O_PSLVERR <= 1'b0;
      end
      else
      begin
         O_PSLVERR <= setup & bad;
      end
   end

   // ****************************************************************
   // software registers of this core
   // ****************************************************************

   // output bits, written under byte lanes at the completion edge
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         own_out_q <= RST_PIN_OUTPUT;
      end
      else if (done & I_PWRITE & (I_PADDR == OFF_PIN_OUTPUT_A))
      begin
         own_out_q <= (own_out_q & ~strb_mask) | (I_PWDATA & strb_mask);
      end
   end

   // drive enables, same write rule
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         own_dir_q <= RST_PIN_DIR;
      end
      else if (done & I_PWRITE & (I_PADDR == OFF_PIN_DIRECTION_A))
      begin
         own_dir_q <= (own_dir_q & ~strb_mask) | (I_PWDATA & strb_mask);
      end
   end

   // field selection; each field written only with its byte lane
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         sel_q <= RST_RANGE_SEL;
      end
      else if (done & I_PWRITE & (I_PADDR == OFF_RANGE_SELECT))
      begin
         if (I_PSTRB[0])
         begin
            sel_q.first <= I_PWDATA[SEL_FIRST_LSB +: 5];
         end
         if (I_PSTRB[1])
         begin
            sel_q.last <= I_PWDATA[SEL_LAST_LSB +: 5];
         end
         if (I_PSTRB[2])
         begin
            sel_q.single <= I_PWDATA[SEL_SINGLE_BIT];
         end
      end
   end

   // ****************************************************************
   // pin drive
   // ****************************************************************

   // wired-or with the other cores: any driver high wins, never a fight
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         O_PIN_OUT <= RST_PIN_OUTPUT;
         O_PIN_OE  <= RST_PIN_DIR;
      end
      else
      begin
         O_PIN_OUT <= own_out_q | I_PEER_OUT;
         O_PIN_OE  <= own_dir_q | I_PEER_DIR;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************

   // width of a forward or reversed range, for the range checks
   always_comb
   begin
      span_w = (sel_q.first < sel_q.last) ? (sel_q.last - sel_q.first)
                                          : (sel_q.first - sel_q.last);
   end

   property p_pin_word_read;
      @(posedge I_CLK) disable iff (I_RESET)
      setup & ~I_PWRITE & (I_PADDR == OFF_PIN_INPUT_STATE_A)
         |=> O_PREADY & ~O_PSLVERR & (O_PRDATA == $past(pin_sync_w));
   endproperty
   a_pin_word_read : assert property (p_pin_word_read)
      else $error("pin word read did not return the sampled pins");

   property p_pin_word_no_write;
      @(posedge I_CLK) disable iff (I_RESET)
      setup & I_PWRITE & (I_PADDR == OFF_PIN_INPUT_STATE_A) |=> O_PREADY & O_PSLVERR;
   endproperty
   a_pin_word_no_write : assert property (p_pin_word_no_write)
      else $error("write to pin word was not refused");

   property p_sync_two_stages;
      @(posedge I_CLK) disable iff (I_RESET)
      !$past(I_RESET) & !$past(I_RESET, 2) |-> pin_sync_w == $past(I_PIN_LEVEL, 2);
   endproperty
   a_sync_two_stages : assert property (p_sync_two_stages)
      else $error("pin levels not delayed by exactly two flops");

   property p_port_b_zero;
      @(posedge I_CLK) disable iff (I_RESET)
      setup & ~I_PWRITE & (I_PADDR == OFF_PIN_INPUT_STATE_B)
         |=> O_PREADY & ~O_PSLVERR & (O_PRDATA == 32'h0000_0000);
   endproperty
   a_port_b_zero : assert property (p_port_b_zero)
      else $error("reserved port returned pin data");

   property p_single_pin;
      @(posedge I_CLK) disable iff (I_RESET)
      setup & ~I_PWRITE & (I_PADDR == OFF_RANGE_RESULT) & sel_q.single
         |=> (O_PRDATA[31:1] == 31'h0000_0000) &
             (O_PRDATA[0] == $past(pin_sync_w[sel_q.first]));
   endproperty
   a_single_pin : assert property (p_single_pin)
      else $error("single pin read misplaced");

   property p_range_low_end;
      @(posedge I_CLK) disable iff (I_RESET)
      setup & ~I_PWRITE & (I_PADDR == OFF_RANGE_RESULT) & ~sel_q.single
         |=> (O_PRDATA[0] == $past(pin_sync_w[sel_q.last])) &
             ((O_PRDATA >> $past(span_w)) >> 1) == 32'h0000_0000;
   endproperty
   a_range_low_end : assert property (p_range_low_end)
      else $error("range read not right aligned");

   property p_range_top;
      @(posedge I_CLK) disable iff (I_RESET)
      setup & ~I_PWRITE & (I_PADDR == OFF_RANGE_RESULT) & ~sel_q.single
         |=> O_PRDATA[$past(span_w)] == $past(pin_sync_w[sel_q.first]);
   endproperty
   a_range_top : assert property (p_range_top)
      else $error("first-named pin not in the top bit of the range");

   property p_wired_or;
      @(posedge I_CLK) disable iff (I_RESET)
      1'b1 |=> (O_PIN_OUT == $past(own_out_q | I_PEER_OUT)) &
               (O_PIN_OE == $past(own_dir_q | I_PEER_DIR));
   endproperty
   a_wired_or : assert property (p_wired_or)
      else $error("pin drive is not the or of all cores");

   property p_ready_one_cycle;
      @(posedge I_CLK) disable iff (I_RESET)
      setup |=> O_PREADY ##1 !O_PREADY;
   endproperty
   a_ready_one_cycle : assert property (p_ready_one_cycle)
      else $error("local read port did not answer in one cycle");

endmodule : per_core_pin_input_port
`default_nettype wire

//--- sim/pin_world.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// board around the pins: outside drivers and the cores' drive
// ****************************************************************
module pin_world
(
   // clock
   input  wire logic        i_clk,
   // outside drive and where it is applied
   input  wire logic [31:0] i_ext,
   input  wire logic [31:0] i_ext_en,
   // resolved drive of all cores
   input  wire logic [31:0] i_out,
   input  wire logic [31:0] i_oe,
   // level seen on each wire
   output var  logic [31:0] o_level
);
   logic [31:0] float_q = 32'h5A5A_5A5A;  // undriven wires wander

   // floating bits flip each cycle so a stale value never passes
   always_ff @(posedge i_clk)
   begin
      float_q <= ~float_q;
   end

   // a driving core wins; the outside drives the rest where enabled, others float
   always_comb
   begin
      o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & float_q);
   end
endmodule : pin_world
`default_nettype wire

//--- sim/per_core_pin_input_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module per_core_pin_input_port_tb_top;
   import pin_port_pkg::*;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic        clk = 1'b0;            // core clock
   logic        rst = 1'b1;            // held for eight edges
   logic        psel = 1'b0;           // apb request
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] prdata;                // apb answer
   logic        pready;
   logic        pslverr;
   logic [31:0] ext = 32'h0;           // outside pin drive
   logic [31:0] ext_en = 32'hFFFF_FFFF;
   logic [31:0] peer_out = 32'h0;      // other cores
   logic [31:0] peer_dir = 32'h0;
   logic [31:0] level;
   logic [31:0] pin_out;
   logic [31:0] pin_oe;
   logic [31:0] seed = 32'h946D_1953;  // fixed so runs repeat
   int          failures = 0;
   int          tests_run = 0;

   always #20 clk = ~clk;

   per_core_pin_input_port u_dut (.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_PIN_LEVEL(level), .I_PEER_OUT(peer_out), .I_PEER_DIR(peer_dir),
      .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe));

   pin_world u_world (.i_clk(clk), .i_ext(ext), .i_ext_en(ext_en), .i_out(pin_out),
      .i_oe(pin_oe), .o_level(level));

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // expected pin field: single bit, or range with first pin on top
   function automatic logic [31:0] field(logic [31:0] v, int f, int l, logic sg);
      logic [31:0] o;
      o = 32'h0;
      if (sg)
         o[0] = v[f];
      else if (f >= l)
         for (int j = 0; j <= f - l; j++) o[j] = v[l + j];
      else
         for (int j = 0; j <= l - f; j++) o[j] = v[l - j];
      return o;
   endfunction : field

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   // one apb transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 50) chk("pready", 32'h1, 32'h0);
   endtask : apb

   task automatic finish_test();
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   // hang guard, far beyond the few hundred cycles used
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      finish_test();
   end

   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial
   begin
      logic [31:0] r, old, od, oo, oe_x, prev_w;
      logic        e, sg;
      int          f, l;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("pin_out reset", 32'h0, pin_out);
      chk("pin_oe reset", 32'h0, pin_oe);
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b0, OFF_PIN_OUTPUT_A + 8'(4 * i), 32'h0, r, e);
         chk("reg reset", 32'h0, r);
      end
      // live pin words: all ones, all zeros, then random
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         ext <= (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : rnd();
         repeat (3) @(posedge clk);
         apb(1'b0, OFF_PIN_INPUT_STATE_A, 32'h0, r, e);
         chk("pin word", ext, r);
      end
      // a change one edge before the setup is still in the synchroniser
      old = ext;
      @(posedge clk);
      ext <= ~old;
      apb(1'b0, OFF_PIN_INPUT_STATE_A, 32'h0, r, e);
      chk("sync lag", old, r);
      apb(1'b0, OFF_PIN_INPUT_STATE_A, 32'h0, r, e);
      chk("sync done", ~old, r);
      // reserved port and refused accesses
      apb(1'b1, OFF_PIN_INPUT_STATE_B, rnd(), r, e);
      chk("port b write err", 32'h0, {31'h0, e});
      apb(1'b0, OFF_PIN_INPUT_STATE_B, 32'h0, r, e);
      chk("port b read", 32'h0, r);
      apb(1'b1, OFF_PIN_INPUT_STATE_A, rnd(), r, e);
      chk("port a write err", 32'h1, {31'h0, e});
      apb(1'b0, OFF_PIN_INPUT_STATE_A, 32'h0, r, e);
      chk("port a unchanged", ~old, r);
      apb(1'b1, OFF_RANGE_RESULT, rnd(), r, e);
      chk("result write err", 32'h1, {31'h0, e});
      apb(1'b0, 8'h20, 32'h0, r, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, r);
      // single pins and ranges, corners first, both orders
      for (int i = 0; i < 24; i++)
      begin
         f = (i == 0) ? 31 : (i == 1) ? 0 : (i == 2) ? 18 : (i == 3) ? 15 : int'(rnd() % 32);
         l = (i == 0) ? 0 : (i == 1) ? 31 : (i == 2) ? 15 : (i == 3) ? 18 : int'(rnd() % 32);
         sg = (i > 3) ? rnd() % 2 : 1'b0;
         @(posedge clk);
         ext <= rnd();
         prev_w = {15'h0, sg, 3'h0, 5'(l), 3'h0, 5'(f)};
         apb(1'b1, OFF_RANGE_SELECT, prev_w, r, e);
         apb(1'b0, OFF_RANGE_RESULT, 32'h0, r, e);
         chk("pin field", field(ext, f, l, sg), r);
      end
      // byte strobe: only the first-pin lane is written
      pstrb <= 4'h1;
      apb(1'b1, OFF_RANGE_SELECT, 32'hFFFF_FFFF, r, e);
      pstrb <= 4'hF;
      apb(1'b0, OFF_RANGE_SELECT, 32'h0, r, e);
      chk("select strobe", (prev_w & 32'hFFFF_FF00) | 32'h1F, r);
      // output bits: only the two middle lanes are written
      pstrb <= 4'h6;
      apb(1'b1, OFF_PIN_OUTPUT_A, 32'hFFFF_FFFF, r, e);
      pstrb <= 4'hF;
      apb(1'b0, OFF_PIN_OUTPUT_A, 32'h0, r, e);
      chk("output strobe", 32'h00FF_FF00, r);
      // own and peer drive: or-combined, and pins read whatever drives them
      for (int i = 0; i < 4; i++)
      begin
         oo = rnd();
         od = rnd();
         peer_out <= rnd();
         peer_dir <= (i == 0) ? 32'h0 : rnd();
         ext <= rnd();
         apb(1'b1, OFF_PIN_OUTPUT_A, oo, r, e);
         apb(1'b1, OFF_PIN_DIRECTION_A, od, r, e);
         repeat (4) @(posedge clk);
         chk("pin_out or", oo | peer_out, pin_out);
         oe_x = od | peer_dir;
         chk("pin_oe or", oe_x, pin_oe);
         apb(1'b0, OFF_PIN_INPUT_STATE_A, 32'h0, r, e);
         chk("driven pins", (oe_x & (oo | peer_out)) | (~oe_x & ext), r);
         apb(1'b0, OFF_PIN_DIRECTION_A, 32'h0, r, e);
         chk("dir readback", od, r);
      end
      finish_test();
   end
endmodule : per_core_pin_input_port_tb_top
`default_nettype wire
